//--- rtl/vpic_ctrl.sv
// Vectored priority interrupt controller: source control, priority, stack, bus slave
`timescale 1ns/100ps
`include "vpic_defines.svh"

module vpic_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fast_irq_pin_i,
    input wire logic [1:0] ext_irq_pins_i,
    input wire logic [7:0] sys_irq_i,
    input wire logic [`VPIC_PERIPH_HI:`VPIC_PERIPH_LO] periph_irq_i,
    output logic fast_req_out_n_o,
    output logic std_req_out_n_o,
    output logic wake_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    vpic_pkg::vpic_mode_type mode_ff [`VPIC_NSRC];
    logic [31:0] vect_ff [`VPIC_NSRC];
    vpic_pkg::vpic_stack_type stack_ff [`VPIC_STACK_DEPTH];
    logic [`VPIC_DEPTH_W-1:0] depth_ff;
    logic [31:0] mask_ff;
    logic [31:0] ffen_ff;
    logic [31:0] spur_ff;
    logic gmask_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic fast_n_ff;
    logic std_n_ff;
    logic wake_ff;
    logic [31:0] raw;
    logic [31:0] active;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] std_cand;
    logic [`VPIC_ADR_W-1:0] adr;
    logic take;
    logic wr;
    logic rd;
    logic ivr_take;
    logic fvr_take;
    logic eos_take;
    logic best_valid;
    logic [`VPIC_SRC_W-1:0] best_src;
    logic [`VPIC_PRIO_W-1:0] best_prio;
    logic std_raw;
    logic fast_raw;
    logic [`VPIC_PRIO_W-1:0] cur_level;
    vpic_pkg::vpic_stack_type top;
    logic [31:0] rd_mux;
    logic [`VPIC_SRC_W-1:0] widx;

    // ------------------------------------------------------------------------
    // Source wiring
    // ------------------------------------------------------------------------
    always_comb begin
        raw = `VPIC_ZERO32;
        raw[`VPIC_FAST_SRC] = fast_irq_pin_i;
        raw[`VPIC_SYS_SRC] = |sys_irq_i;
        raw[`VPIC_PERIPH_HI:`VPIC_PERIPH_LO] = periph_irq_i;
        raw[`VPIC_EXT_LO_SRC] = ext_irq_pins_i[0];
        raw[`VPIC_EXT_HI_SRC] = ext_irq_pins_i[1];
    end

    // Pins feed the same stage as internal lines but add a two-cycle synchroniser delay
    genvar gi;
    generate
        for (gi = 0; gi < `VPIC_NSRC; gi++) begin : g_src
            vpic_src_stage #(
                .IS_EXT((gi == 0) || (gi >= `VPIC_EXT_LO_SRC))
            ) u_stage (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .raw_i(raw[gi]),
                .trig_i(mode_ff[gi].trig),
                .set_i(set_vec[gi]),
                .clr_i(clr_vec[gi]),
                .active_o(active[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    assign adr = wb_adr_i[`VPIC_ADR_W-1:0];
    assign widx = adr[6:2];
    assign take = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = take & wb_we_i;
    assign rd = take & ~wb_we_i;
    assign ivr_take = rd && (adr == `VPIC_STD_VECT);
    assign fvr_take = rd && (adr == `VPIC_FAST_VECT);
    assign eos_take = wr && (adr == `VPIC_EOS_CMD);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= take;
        end
    end

    assign wb_ack_o = ack_ff;

    // ------------------------------------------------------------------------
    // Mode and vector registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `VPIC_NSRC; i++) begin
                mode_ff[i] <= '0;
                vect_ff[i] <= `VPIC_ZERO32;
            end
        end else if (wr && (adr[8:7] == `VPIC_MODE_REGION) && wb_sel_i[0]) begin
            mode_ff[widx].prio <= wb_dat_i[`VPIC_PRIO_LSB +: `VPIC_PRIO_W];
            mode_ff[widx].trig <= vpic_pkg::vpic_trig_type'(wb_dat_i[`VPIC_TRIG_LSB +: 2]);
        end else if (wr && (adr[8:7] == `VPIC_VECT_REGION)) begin
            vect_ff[widx] <= merge(vect_ff[widx], wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spur_ff <= `VPIC_ZERO32;
        end else if (wr && (adr == `VPIC_SPUR_VECT)) begin
            spur_ff <= merge(spur_ff, wb_dat_i, wb_sel_i);
        end
    end

    // ------------------------------------------------------------------------
    // Enable mask, fast forcing, general mask
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff <= `VPIC_ZERO32;
        end else if (wr && (adr == `VPIC_EN_CMD)) begin
            mask_ff <= mask_ff | wb_dat_i;
        end else if (wr && (adr == `VPIC_DIS_CMD)) begin
            mask_ff <= mask_ff & ~wb_dat_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ffen_ff <= `VPIC_ZERO32;
        end else if (wr && (adr == `VPIC_FF_EN)) begin
            ffen_ff <= ffen_ff | wb_dat_i;
        end else if (wr && (adr == `VPIC_FF_DIS)) begin
            ffen_ff <= ffen_ff & ~wb_dat_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gmask_ff <= 1'b0;
        end else if (wr && (adr == `VPIC_GEN_MASK) && wb_sel_i[0]) begin
            gmask_ff <= wb_dat_i[`VPIC_GMASK_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Set, clear and automatic clear
    // ------------------------------------------------------------------------
    always_comb begin
        set_vec = (wr && (adr == `VPIC_SET_CMD)) ? wb_dat_i : `VPIC_ZERO32;
        clr_vec = (wr && (adr == `VPIC_CLR_CMD)) ? wb_dat_i : `VPIC_ZERO32;
        if (ivr_take && best_valid) begin
            clr_vec[best_src] = 1'b1;
        end
        if (fvr_take) begin
            clr_vec[`VPIC_FAST_SRC] = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Priority resolution
    // ------------------------------------------------------------------------
    // Forced sources never compete here, so they are never auto-cleared here
    assign std_cand = active & mask_ff & ~ffen_ff & ~32'h0000_0001;

    always_comb begin
        best_valid = 1'b0;
        best_src = '0;
        best_prio = '0;
        // Downward scan with >= leaves the lowest number on ties
        for (int i = `VPIC_NSRC - 1; i > 0; i--) begin
            if (std_cand[i] && (!best_valid || (mode_ff[i].prio >= best_prio))) begin
                best_valid = 1'b1;
                best_src = `VPIC_SRC_W'(i);
                best_prio = mode_ff[i].prio;
            end
        end
    end

    assign top = stack_ff[3'(depth_ff - `VPIC_DEPTH_W'(1))];
    assign cur_level = top.level;
    // Only a strictly higher level reopens the request while one is in service
    assign std_raw = best_valid && ((depth_ff == '0) || (best_prio > cur_level));
    assign fast_raw = |(active & mask_ff & (ffen_ff | 32'h0000_0001));

    // ------------------------------------------------------------------------
    // Nesting stack
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            depth_ff <= '0;
            for (int i = 0; i < `VPIC_STACK_DEPTH; i++) begin
                stack_ff[i] <= '0;
            end
        end else if (ivr_take && best_valid && (depth_ff < `VPIC_STACK_DEPTH)) begin
            stack_ff[depth_ff[2:0]] <= '{level: best_prio, src: best_src};
            depth_ff <= depth_ff + `VPIC_DEPTH_W'(1);
        end else if (eos_take && (depth_ff != '0)) begin
            depth_ff <= depth_ff - `VPIC_DEPTH_W'(1);
        end
    end

    // ------------------------------------------------------------------------
    // Request outputs, no clock gating anywhere in the block
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fast_n_ff <= 1'b1;
            std_n_ff <= 1'b1;
            wake_ff <= 1'b0;
        end else begin
            fast_n_ff <= ~(fast_raw & ~gmask_ff);
            std_n_ff <= ~(std_raw & ~gmask_ff & ~ivr_take);
            wake_ff <= fast_raw | std_raw;
        end
    end

    assign fast_req_out_n_o = fast_n_ff;
    assign std_req_out_n_o = std_n_ff;
    assign wake_o = wake_ff;

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always_comb begin
        rd_mux = `VPIC_ZERO32;
        if (adr[8:7] == `VPIC_MODE_REGION) begin
            rd_mux[`VPIC_PRIO_LSB +: `VPIC_PRIO_W] = mode_ff[widx].prio;
            rd_mux[`VPIC_TRIG_LSB +: 2] = mode_ff[widx].trig;
        end else if (adr[8:7] == `VPIC_VECT_REGION) begin
            rd_mux = vect_ff[widx];
        end else begin
            case (adr)
                `VPIC_STD_VECT: rd_mux = best_valid ? vect_ff[best_src] : spur_ff;
                `VPIC_FAST_VECT: rd_mux = vect_ff[`VPIC_FAST_SRC];
                `VPIC_CUR_SRC: rd_mux[`VPIC_SRC_W-1:0] = (depth_ff != '0) ? top.src : '0;
                `VPIC_PENDING: rd_mux = active;
                `VPIC_MASK: rd_mux = mask_ff;
                `VPIC_CORE_STAT: begin
                    rd_mux[`VPIC_CORE_FAST_BIT] = ~fast_n_ff;
                    rd_mux[`VPIC_CORE_STD_BIT] = ~std_n_ff;
                end
                `VPIC_SPUR_VECT: rd_mux = spur_ff;
                `VPIC_FF_STAT: rd_mux = ffen_ff;
                `VPIC_GEN_MASK: rd_mux[`VPIC_GMASK_BIT] = gmask_ff;
                default: rd_mux = `VPIC_ZERO32;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_ff <= `VPIC_ZERO32;
        end else if (rd) begin
            rdat_ff <= rd_mux;
        end
    end

    assign wb_dat_o = rdat_ff;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_std_vect_read;
        ivr_take && best_valid && (depth_ff < `VPIC_STACK_DEPTH);
    endsequence

    sequence s_pushed;
        (depth_ff == $past(depth_ff) + `VPIC_DEPTH_W'(1)) && (top.src == $past(best_src));
    endsequence

    a_reset_lines_high: assert property (@(posedge clk_i)
        rst_i |=> (fast_req_out_n_o && std_req_out_n_o && (mask_ff == `VPIC_ZERO32)))
        else $error("requests not idle after reset");

    a_gmask_holds_lines: assert property (@(posedge clk_i) disable iff (rst_i)
        gmask_ff |=> (fast_req_out_n_o && std_req_out_n_o))
        else $error("request asserted under general mask");

    a_request_wakes: assert property (@(posedge clk_i) disable iff (rst_i)
        (!std_req_out_n_o || !fast_req_out_n_o) |-> wake_o)
        else $error("request without wake");

    a_enable_sets_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && (adr == `VPIC_EN_CMD)) |=> ((mask_ff & $past(wb_dat_i)) == $past(wb_dat_i)))
        else $error("enable command lost");

    a_mask_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && (adr == `VPIC_MASK)) |=> (wb_ack_o && (wb_dat_o == $past(mask_ff))))
        else $error("mask readback wrong");

    a_vector_push: assert property (@(posedge clk_i) disable iff (rst_i)
        s_std_vect_read |=> s_pushed ##0 std_req_out_n_o)
        else $error("vector read did not push or deassert");

    a_fast_autoclear: assert property (@(posedge clk_i) disable iff (rst_i)
        fvr_take |-> clr_vec[`VPIC_FAST_SRC])
        else $error("fast vector read did not clear source zero");

    a_eos_pops: assert property (@(posedge clk_i) disable iff (rst_i)
        (eos_take && (depth_ff != '0)) |=> (depth_ff == $past(depth_ff) - `VPIC_DEPTH_W'(1)))
        else $error("end of service did not pop");

    a_forced_no_std: assert property (@(posedge clk_i) disable iff (rst_i)
        best_valid |-> !ffen_ff[best_src])
        else $error("forced source on standard path");

endmodule

//--- rtl/vpic_defines.svh
// Register map, field positions and constants of the vectored interrupt controller
`ifndef VPIC_DEFINES_SVH
`define VPIC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define VPIC_NSRC 32
`define VPIC_SRC_W 5
`define VPIC_PRIO_W 3
`define VPIC_STACK_DEPTH 4'h8
`define VPIC_DEPTH_W 4
`define VPIC_ADR_W 9

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define VPIC_MODE_BASE 9'h000
`define VPIC_VECT_BASE 9'h080
`define VPIC_STD_VECT 9'h100
`define VPIC_FAST_VECT 9'h104
`define VPIC_CUR_SRC 9'h108
`define VPIC_PENDING 9'h10c
`define VPIC_MASK 9'h110
`define VPIC_CORE_STAT 9'h114
`define VPIC_EN_CMD 9'h120
`define VPIC_DIS_CMD 9'h124
`define VPIC_CLR_CMD 9'h128
`define VPIC_SET_CMD 9'h12c
`define VPIC_EOS_CMD 9'h130
`define VPIC_SPUR_VECT 9'h134
`define VPIC_FF_EN 9'h140
`define VPIC_FF_DIS 9'h144
`define VPIC_FF_STAT 9'h148
`define VPIC_GEN_MASK 9'h14c
// Address bits [8:7] pick the mode or the vector bank
`define VPIC_MODE_REGION 2'h0
`define VPIC_VECT_REGION 2'h1

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define VPIC_PRIO_LSB 0
`define VPIC_TRIG_LSB 5
`define VPIC_CORE_FAST_BIT 0
`define VPIC_CORE_STD_BIT 1
`define VPIC_GMASK_BIT 0
`define VPIC_ZERO32 32'h0000_0000
`define VPIC_TRIG_LOW_LEVEL 2'h0
`define VPIC_TRIG_NEG_EDGE 2'h1
`define VPIC_TRIG_HIGH_LEVEL 2'h2
`define VPIC_TRIG_POS_EDGE 2'h3
`define VPIC_FAST_SRC 5'h00
`define VPIC_SYS_SRC 1
`define VPIC_EXT_LO_SRC 30
`define VPIC_EXT_HI_SRC 31
`define VPIC_PERIPH_LO 2
`define VPIC_PERIPH_HI 29

`endif

//--- rtl/vpic_pkg.sv
// Types shared by the interrupt controller modules
package vpic_pkg;
`include "vpic_defines.svh"

    typedef enum logic [1:0] {
        VPIC_LOW_LEVEL = `VPIC_TRIG_LOW_LEVEL,
        VPIC_NEG_EDGE = `VPIC_TRIG_NEG_EDGE,
        VPIC_HIGH_LEVEL = `VPIC_TRIG_HIGH_LEVEL,
        VPIC_POS_EDGE = `VPIC_TRIG_POS_EDGE
    } vpic_trig_type;

    typedef struct packed {
        vpic_trig_type trig;
        logic [`VPIC_PRIO_W-1:0] prio;
    } vpic_mode_type;

    typedef struct packed {
        logic [`VPIC_PRIO_W-1:0] level;
        logic [`VPIC_SRC_W-1:0] src;
    } vpic_stack_type;

endpackage

//--- rtl/vpic_src_stage.sv
// One interrupt source input stage: synchroniser, trigger select, edge latch
`timescale 1ns/100ps
`include "vpic_defines.svh"

module vpic_src_stage #(
    parameter bit IS_EXT = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic raw_i,
    input wire vpic_pkg::vpic_trig_type trig_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic active_o
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic latch_ff;
    logic in_lvl;
    logic is_edge;
    logic pos_pol;
    logic det;

    // ------------------------------------------------------------------------
    // Input qualification
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_i;
            sync2_ff <= sync1_ff;
        end
    end

    // Internal lines share the clock, so they skip the synchroniser
    assign in_lvl = IS_EXT ? sync2_ff : raw_i;
    assign is_edge = trig_i[0];
    // Internal lines only know level or edge, active level fixed high
    assign pos_pol = IS_EXT ? trig_i[1] : 1'b1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= in_lvl;
        end
    end

    assign det = pos_pol ? (in_lvl & ~prev_ff) : (~in_lvl & prev_ff);

    // ------------------------------------------------------------------------
    // Edge memory; set wins over a clear in the same cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_ff <= 1'b0;
        end else if (!is_edge) begin
            latch_ff <= 1'b0;
        end else if (det || set_i) begin
            latch_ff <= 1'b1;
        end else if (clr_i) begin
            latch_ff <= 1'b0;
        end
    end

    assign active_o = is_edge ? latch_ff : (pos_pol ? in_lvl : ~in_lvl);

    a_set_wins_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (is_edge && set_i) |=> latch_ff)
        else $error("edge latch not set by set command");

    a_level_no_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        (!is_edge && $past(!is_edge)) |-> !latch_ff)
        else $error("level source holds an edge latch");

endmodule

//--- tb/vpic_core_model.sv
// Processor core side: notes wake-ups and request levels
`timescale 1ns/100ps

module vpic_core_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic fast_req_n_i,
    input wire logic std_req_n_i,
    input wire logic wake_i,
    output logic woke_o,
    output logic irq_seen_o
);
    // Sticky so a one-cycle wake is not missed
    always_ff @(posedge clk_i) begin
        if (clr_i) begin
            woke_o <= 1'b0;
            irq_seen_o <= 1'b0;
        end else begin
            woke_o <= woke_o | wake_i;
            irq_seen_o <= irq_seen_o | ~fast_req_n_i | ~std_req_n_i;
        end
    end
endmodule

//--- tb/vpic_ctrl_test.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps

module vpic_ctrl_test;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, clr = 1'b1;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, rd;
    logic [3:0] sel = 4'h0;
    logic ack, fast_n, std_n, wake, woke, seen;
    logic [29:2] periph = 28'h0;
    // Pins idle high so sources left at low level stay quiet
    logic fpin = 1'b1;
    logic [1:0] epins = 2'h3;
    logic [7:0] system_source = 8'h00;
    int err_total = 0, samples_checked = 0;

    always #2.5 clk_i = ~clk_i;

    vpic_ctrl i_vpic_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .fast_irq_pin_i(fpin), .ext_irq_pins_i(epins), .sys_irq_i(system_source),
        .periph_irq_i(periph), .fast_req_out_n_o(fast_n), .std_req_out_n_o(std_n), .wake_o(wake));
    vpic_core_model i_vpic_core_model (.clk_i(clk_i), .clr_i(clr), .fast_req_n_i(fast_n),
        .std_req_n_i(std_n), .wake_i(wake), .woke_o(woke), .irq_seen_o(seen));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until ack is sampled high; one idle cycle after
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) begin
                break;
            end
        end
        if (n == 20) begin
            err_total++;
            report_and_stop();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task automatic t_reset();
        rchk("mask", 32'h110, 32'h0);
        rchk("core", 32'h114, 32'h0);
        chk("reqs", 32'h3, {30'h0, fast_n, std_n});
        bus(1'b1, 32'h120, 32'h30);
        bus(1'b1, 32'h124, 32'h10);
        rchk("mask", 32'h110, 32'h20);
        bus(1'b1, 32'h124, 32'h20);
        $display("reset and mask test done");
    endtask

    task automatic t_level();
        bus(1'b1, 32'h094, 32'h1234);
        @(posedge clk_i);
        periph[5] <= 1'b1;
        rchk("pend", 32'h10c, 32'h20);
        bus(1'b1, 32'h120, 32'h20);
        repeat (3) @(posedge clk_i);
        chk("std_n", 32'h0, {31'h0, std_n});
        rchk("core", 32'h114, 32'h2);
        rchk("ivec", 32'h100, 32'h1234);
        rchk("cur", 32'h108, 32'h5);
        chk("std_n", 32'h1, {31'h0, std_n});
        @(posedge clk_i);
        periph[5] <= 1'b0;
        bus(1'b1, 32'h130, 32'h0);
        bus(1'b1, 32'h124, 32'h20);
        $display("level test done");
    endtask

    task automatic t_edge();
        bus(1'b1, 32'h01c, 32'h62);
        bus(1'b1, 32'h020, 32'h62);
        bus(1'b1, 32'h09c, 32'h77);
        bus(1'b1, 32'h12c, 32'h1c0);
        rchk("pend", 32'h10c, 32'h180);
        bus(1'b1, 32'h128, 32'h100);
        rchk("pend", 32'h10c, 32'h80);
        bus(1'b1, 32'h12c, 32'h100);
        bus(1'b1, 32'h120, 32'h180);
        rchk("ivec", 32'h100, 32'h77);
        rchk("pend", 32'h10c, 32'h100);
        bus(1'b1, 32'h128, 32'h100);
        bus(1'b1, 32'h130, 32'h0);
        bus(1'b1, 32'h124, 32'h180);
        $display("edge test done");
    endtask

    task automatic t_fast();
        bus(1'b1, 32'h000, 32'h60);
        bus(1'b1, 32'h080, 32'h55);
        bus(1'b1, 32'h12c, 32'h1);
        bus(1'b1, 32'h120, 32'h1);
        repeat (3) @(posedge clk_i);
        chk("fast_n", 32'h0, {31'h0, fast_n});
        rchk("core", 32'h114, 32'h1);
        rchk("fvec", 32'h104, 32'h55);
        rchk("pend", 32'h10c, 32'h0);
        bus(1'b1, 32'h124, 32'h1);
        $display("fast test done");
    endtask

    task automatic t_ext();
        @(posedge clk_i);
        system_source <= 8'h10;
        rchk("pend", 32'h10c, 32'h2);
        system_source <= 8'h00;
        bus(1'b1, 32'h078, 32'h20);
        fpin <= 1'b0;
        epins <= 2'h2;
        // Room for the two synchroniser stages and the edge latch
        repeat (4) @(posedge clk_i);
        fpin <= 1'b1;
        epins <= 2'h3;
        repeat (4) @(posedge clk_i);
        rchk("pend", 32'h10c, 32'h4000_0001);
        bus(1'b1, 32'h128, 32'h4000_0001);
        bus(1'b1, 32'h07c, 32'h40);
        rchk("pend", 32'h10c, 32'h8000_0000);
        bus(1'b1, 32'h07c, 32'h0);
        bus(1'b1, 32'h134, 32'h99);
        bus(1'b1, 32'h140, 32'h80);
        bus(1'b1, 32'h12c, 32'h80);
        bus(1'b1, 32'h120, 32'h80);
        repeat (3) @(posedge clk_i);
        chk("fast_n", 32'h0, {31'h0, fast_n});
        chk("std_n", 32'h1, {31'h0, std_n});
        rchk("ivec", 32'h100, 32'h99);
        rchk("pend", 32'h10c, 32'h80);
        bus(1'b1, 32'h128, 32'h80);
        bus(1'b1, 32'h124, 32'h80);
        bus(1'b1, 32'h144, 32'h80);
        $display("external, system and forcing test done");
    endtask

    task automatic t_gmask();
        bus(1'b1, 32'h14c, 32'h1);
        @(posedge clk_i);
        clr <= 1'b0;
        periph[5] <= 1'b1;
        bus(1'b1, 32'h120, 32'h20);
        repeat (3) @(posedge clk_i);
        chk("woke", 32'h1, {31'h0, woke});
        chk("seen", 32'h0, {31'h0, seen});
        @(posedge clk_i);
        periph[5] <= 1'b0;
        bus(1'b1, 32'h124, 32'h20);
        $display("general mask test done");
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_level();
        t_edge();
        t_fast();
        t_ext();
        t_gmask();
        report_and_stop();
    end
endmodule
